// ---- qps_pkg.sv ----
// Shared constants, types and helpers for the quad pot serial link.
// Assumes both ends run on one 10 MHz sys_clk.
package qps_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_PERIOD_NS = 800;
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [2:0] HALF_LAST = 3'(SCK_HALF_CYC - 1);
  localparam int NV_WRITE_CYC_DEF = 64;

  localparam int NPOT = 4;
  localparam int NSLOT = 4;
  localparam int WW = 6;
  localparam logic [5:0] TAP_MIN = 6'h00;
  localparam logic [5:0] TAP_MAX = 6'h3f;
  localparam logic [5:0] NV_INIT = 6'h20;
  localparam logic [1:0] BOOT_SLOT = 2'h0;

  // Bit counters within a frame
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_SLOT = 3'h1;
  localparam logic [3:0] FRAME_LAST = 4'hf;

  // Instruction byte: op, device address, pot
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 4;
  localparam int ADDR_MSB = 3;
  localparam int ADDR_LSB = 2;
  localparam int POT_MSB = 1;
  localparam int POT_LSB = 0;
  // Data byte: slot, value; value msb doubles as copy direction
  localparam int SLOT_MSB = 7;
  localparam int SLOT_LSB = 6;
  localparam int VAL_MSB = 5;
  localparam int VAL_LSB = 0;
  localparam int COPY_DIR = 5;

  typedef enum logic [3:0] {
    OP_RD_WIPER = 4'h9,
    OP_WR_WIPER = 4'ha,
    OP_RD_SLOT = 4'hb,
    OP_WR_SLOT = 4'hc,
    OP_COPY = 4'hd,
    OP_STEP = 4'h2
  } qps_op_t;

  typedef logic [NPOT-1:0][WW-1:0] qps_wipers_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
    logic a_msb;
    logic a_lsb;
  } qps_pins_t;

  localparam qps_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
    hold_n: 1'b1, wp_n: 1'b1, a_msb: 1'b0, a_lsb: 1'b0};

  function automatic logic qps_op_ok(input logic [3:0] op);
    return op inside {OP_RD_WIPER, OP_WR_WIPER, OP_RD_SLOT, OP_WR_SLOT,
                      OP_COPY, OP_STEP};
  endfunction : qps_op_ok

  function automatic logic [3:0] qps_slot_idx(input logic [1:0] pot,
                                              input logic [1:0] slot);
    return {pot, slot};
  endfunction : qps_slot_idx

  function automatic logic [5:0] qps_step(input logic [5:0] w,
                                          input logic up);
    if (up) begin
      return (w == TAP_MAX) ? w : w + 6'h01;
    end
    return (w == TAP_MIN) ? w : w - 6'h01;
  endfunction : qps_step

endpackage : qps_pkg

// ---- qps_link_if.sv ----
// Link between the pot device end and the serial master end.
// The serial output is open when not driven and reads as a pulled-up 1.
`timescale 1ns/1ps
`default_nettype none
interface qps_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic wp_n;
  logic so_o;
  logic so_oe;
  logic so;

  assign so = so_oe ? so_o : 1'b1;

  modport dev (input cs_n, input sck, input si, input hold_n, input wp_n,
               output so_o, output so_oe);
  modport host (output cs_n, output sck, output si, output hold_n,
                output wp_n, input so);
endinterface : qps_link_if
`default_nettype wire

// ---- qps_dev.sv ----
// Device end: serial control of four 64-tap wipers and sixteen slots.
// Assumes the link pins are asynchronous to sys_clk and sck is slow
// enough for four or more sys_clk cycles per half period.
//
// How it works
// (R1) Sample serial input on rising clock
// (R2) Shift serial output on falling clock
// (R3) Works in modes (0,0) and (1,1)
// (R4) Answer only when straps match address
// (R5) Deselected: output off, standby unless writing
// (R6) Frame starts at chip select fall
// (R7) Slot write starts at chip select rise
// (R8) Write protect blocks slot writes only
// (R9) Protect fall aborts pending write only
// (R10) Pause with clock low freezes link
// (R11) Master keeps pause high when unused
// (R12) First byte goes to instruction register
// (R13) First byte holds one of six opcodes
// (R14) Four 6-bit wiper setting registers
// (R15) Sixteen 6-bit non-volatile setting slots
// (R16) Reset loads boot slot into wipers
// (R17) All wipers and slots readable, writable
// (R18) Copy between wiper and own slots
// (R19) Step mode moves wiper one tap per clock rise
// (R20) Bad opcode or address: ignore frame
// (R21) Stepping saturates at taps 0, 63
`timescale 1ns/1ps
`default_nettype none
module qps_dev
  import qps_pkg::*;
#(
  parameter int NV_WRITE_CYC = NV_WRITE_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic resetn,
  qps_link_if.dev bus,
  input wire logic strap_addr_lsb,
  input wire logic strap_addr_msb,
  output logic [NPOT-1:0][WW-1:0] wiper_setting_reg,
  output logic standby,
  output logic nv_busy
);

  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_INSTR = 3'b001,
    DS_DATA = 3'b011,
    DS_STEP = 3'b110,
    DS_IGNORE = 3'b010
  } qps_dst_t;

  localparam logic [15:0] NV_CNT_LAST = 16'(NV_WRITE_CYC - 1);

  qps_pins_t meta_r;
  qps_pins_t sync_r;
  logic sck_d_r;
  logic cs_d_r;
  logic wp_d_r;
  logic hold_act_r;
  qps_dst_t st_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic [3:0] op_r;
  logic [1:0] pot_r;
  logic [1:0] slot_r;
  logic [5:0] out_r;
  logic so_r;
  logic so_en_r;
  logic rd_arm_r;
  qps_wipers_t wiper_r;
  logic [5:0] nv_setting_slot [NPOT*NSLOT];
  logic recall_r;
  logic pend_r;
  logic [3:0] pend_idx_r;
  logic [5:0] pend_val_r;
  logic busy_r;
  logic [15:0] busy_cnt_r;
  logic standby_r;

  logic active;
  logic rise;
  logic fall;
  logic cs_rise;
  logic wp_fall;
  logic byte_done;
  logic is_read;
  logic [7:0] byte_in;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_r <= PINS_IDLE;
      sync_r <= PINS_IDLE;
    end else begin
      meta_r <= '{cs_n: bus.cs_n, sck: bus.sck, si: bus.si,
                  hold_n: bus.hold_n, wp_n: bus.wp_n,
                  a_msb: strap_addr_msb, a_lsb: strap_addr_lsb};
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sck_d_r <= PINS_IDLE.sck;
      cs_d_r <= PINS_IDLE.cs_n;
      wp_d_r <= PINS_IDLE.wp_n;
    end else begin
      sck_d_r <= sync_r.sck;
      cs_d_r <= sync_r.cs_n;
      wp_d_r <= sync_r.wp_n;
    end
  end

  // Pause only changes while sck is low, so no edge is lost or invented
  always_ff @(posedge sys_clk) begin
    if (!resetn || sync_r.cs_n) begin
      hold_act_r <= 1'b0;
    end else if (!sync_r.sck) begin
      hold_act_r <= !sync_r.hold_n; // [R10]
    end
  end

  // Both edges are tracked, so idle-high and idle-low clocks both work
  assign active = !sync_r.cs_n && !hold_act_r; // [R10]
  assign rise = active && sync_r.sck && !sck_d_r; // [R1] [R3]
  assign fall = active && !sync_r.sck && sck_d_r; // [R2] [R3]
  assign cs_rise = sync_r.cs_n && !cs_d_r;
  assign wp_fall = wp_d_r && !sync_r.wp_n;
  assign byte_in = {sh_r[6:0], sync_r.si};
  assign byte_done = rise && (st_r == DS_DATA) && (bit_r == BIT_LAST);
  assign is_read = (op_r == OP_RD_WIPER) || (op_r == OP_RD_SLOT);

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer

  always_ff @(posedge sys_clk) begin
    if (!resetn || sync_r.cs_n) begin
      st_r <= DS_IDLE;
      bit_r <= 3'h0;
    end else begin
      unique case (st_r)
        // Low cs seen in idle is the fall; a busy part sits the frame out
        DS_IDLE: begin
          st_r <= busy_r ? DS_IGNORE : DS_INSTR; // [R6]
        end
        DS_INSTR: begin
          if (rise) begin
            bit_r <= bit_r + 3'h1;
            if (bit_r == BIT_LAST) begin
              if (byte_in[ADDR_MSB:ADDR_LSB] !=
                  {sync_r.a_msb, sync_r.a_lsb} ||
                  !qps_op_ok(byte_in[OP_MSB:OP_LSB])) begin
                st_r <= DS_IGNORE; // [R4] [R13] [R20]
              end else if (byte_in[OP_MSB:OP_LSB] == OP_STEP) begin
                st_r <= DS_STEP; // [R19]
              end else begin
                st_r <= DS_DATA;
              end
            end
          end
        end
        DS_DATA: begin
          if (rise) begin
            bit_r <= bit_r + 3'h1;
            // One action per frame; later bits are dropped
            if (bit_r == BIT_LAST) begin
              st_r <= DS_IGNORE;
            end
          end
        end
        DS_STEP, DS_IGNORE: begin
          st_r <= st_r; // [R20]
        end
        default: begin
          st_r <= DS_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sh_r <= 8'h00;
      op_r <= 4'h0;
      pot_r <= 2'h0;
      slot_r <= 2'h0;
    end else if (rise) begin
      sh_r <= byte_in; // [R1]
      if (st_r == DS_INSTR && bit_r == BIT_LAST) begin
        op_r <= byte_in[OP_MSB:OP_LSB]; // [R12]
        pot_r <= byte_in[POT_MSB:POT_LSB];
      end
      if (st_r == DS_DATA && bit_r == BIT_SLOT) begin
        slot_r <= byte_in[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path: value launches on the fall after the slot bits

  always_ff @(posedge sys_clk) begin
    if (!resetn || sync_r.cs_n) begin
      so_r <= 1'b0;
      so_en_r <= 1'b0;
      rd_arm_r <= 1'b0;
      out_r <= 6'h00;
    end else begin
      if (rise && st_r == DS_DATA && bit_r == BIT_SLOT && is_read) begin
        rd_arm_r <= 1'b1;
        out_r <= (op_r == OP_RD_WIPER) ? wiper_r[pot_r] :
                 nv_setting_slot[qps_slot_idx(pot_r, byte_in[1:0])]; // [R17]
      end else if (byte_done) begin
        rd_arm_r <= 1'b0;
      end else if (fall && rd_arm_r) begin
        so_r <= out_r[VAL_MSB]; // [R2]
        out_r <= {out_r[4:0], 1'b0};
        so_en_r <= 1'b1;
      end
    end
  end

  assign bus.so_o = so_r;
  assign bus.so_oe = so_en_r && active; // [R5] [R10]

  ////////////////////////////////////////////////////////////////////////
  // Wiper setting registers

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      recall_r <= 1'b1;
      wiper_r <= '0;
    end else if (recall_r) begin
      recall_r <= 1'b0;
      for (int i = 0; i < NPOT; i++) begin
        wiper_r[i] <= nv_setting_slot[qps_slot_idx(2'(i), BOOT_SLOT)]; // [R16]
      end
    end else if (rise && st_r == DS_STEP) begin
      wiper_r[pot_r] <= qps_step(wiper_r[pot_r], sync_r.si); // [R19] [R21]
    end else if (byte_done) begin
      if (op_r == OP_WR_WIPER) begin
        wiper_r[pot_r] <= byte_in[VAL_MSB:VAL_LSB]; // [R14] [R17]
      end else if (op_r == OP_COPY && !byte_in[COPY_DIR]) begin
        wiper_r[pot_r] <= nv_setting_slot[qps_slot_idx(pot_r, slot_r)]; // [R18]
      end
    end
  end

  assign wiper_setting_reg = wiper_r;

  ////////////////////////////////////////////////////////////////////////
  // Non-volatile slots; content is restored to NV_INIT by resetn,
  // standing in for factory content in this model.

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pend_r <= 1'b0;
      pend_idx_r <= 4'h0;
      pend_val_r <= 6'h00;
      busy_r <= 1'b0;
      busy_cnt_r <= 16'h0000;
      for (int i = 0; i < NPOT * NSLOT; i++) begin
        nv_setting_slot[i] <= NV_INIT; // [R15]
      end
    end else if (busy_r) begin
      // Data is latched, so protect changes no longer matter
      busy_cnt_r <= busy_cnt_r + 16'h0001;
      if (busy_cnt_r == NV_CNT_LAST) begin
        busy_r <= 1'b0;
        nv_setting_slot[pend_idx_r] <= pend_val_r; // [R17] [R18]
      end
    end else if (cs_rise && pend_r) begin
      busy_r <= 1'b1; // [R7]
      busy_cnt_r <= 16'h0000;
      pend_r <= 1'b0;
    end else if (sync_r.cs_n || wp_fall) begin
      pend_r <= 1'b0; // [R9]
    end else if (byte_done && sync_r.wp_n &&
                 (op_r == OP_WR_SLOT ||
                  (op_r == OP_COPY && byte_in[COPY_DIR]))) begin
      pend_r <= 1'b1; // [R8]
      pend_idx_r <= qps_slot_idx(pot_r, slot_r);
      pend_val_r <= (op_r == OP_WR_SLOT) ? byte_in[VAL_MSB:VAL_LSB] :
                    wiper_r[pot_r];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      standby_r <= 1'b0;
    end else begin
      // A latched write counts as busy, so standby never blinks on
      standby_r <= sync_r.cs_n && !busy_r && !pend_r; // [R5]
    end
  end

  assign standby = standby_r;
  assign nv_busy = busy_r;

endmodule : qps_dev
`default_nettype wire

// ---- qps_host.sv ----
// Master end: sends one two-byte frame per request over the link.
// Assumes the device end synchronises the pins; sck is divided here.
`timescale 1ns/1ps
`default_nettype none
module qps_host
  import qps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  qps_link_if.host bus,
  input wire logic mode_cpol,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_instr,
  input wire logic [7:0] req_data,
  input wire logic pause,
  input wire logic protect,
  output logic [5:0] rd_data,
  output logic done
);

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LEAD = 3'b001,
    HS_LOW = 3'b011,
    HS_HIGH = 3'b010,
    HS_TAIL = 3'b110
  } qps_hst_t;

  qps_hst_t st_r;
  logic [2:0] cnt_r;
  logic [3:0] n_r;
  logic [15:0] tx_r;
  logic [5:0] rx_r;
  logic cpol_r;
  logic cs_n_r;
  logic sck_r;
  logic si_r;
  logic hold_n_r;
  logic wp_n_r;
  logic miso_m_r;
  logic miso_s_r;
  logic [5:0] rd_data_r;
  logic done_r;

  ////////////////////////////////////////////////////////////////////////
  // Return data synchroniser

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      miso_m_r <= 1'b1;
      miso_s_r <= 1'b1;
    end else begin
      miso_m_r <= bus.so;
      miso_s_r <= miso_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer and clock divider

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= HS_IDLE;
      cnt_r <= 3'h0;
      n_r <= 4'h0;
      tx_r <= 16'h0000;
      rx_r <= 6'h00;
      cpol_r <= 1'b0;
      cs_n_r <= 1'b1;
      sck_r <= 1'b0;
      si_r <= 1'b0;
      hold_n_r <= 1'b1;
      rd_data_r <= 6'h00;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (st_r)
        HS_IDLE: begin
          sck_r <= mode_cpol; // [R3]
          cpol_r <= mode_cpol;
          if (req_valid) begin
            tx_r <= {req_instr, req_data};
            cs_n_r <= 1'b0; // [R6]
            cnt_r <= 3'h0;
            st_r <= HS_LEAD;
          end
        end
        HS_LEAD: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == HALF_LAST) begin
            sck_r <= 1'b0;
            si_r <= tx_r[15];
            n_r <= 4'h0;
            cnt_r <= 3'h0;
            st_r <= HS_LOW;
          end
        end
        HS_LOW: begin
          // Pause only while sck is low, and only at the start of the
          // low half, so the device never sees pause beside an edge
          if (!hold_n_r) begin
            if (!pause) begin
              hold_n_r <= 1'b1; // [R10] [R11]
              cnt_r <= 3'h0;
            end
          end else if (pause && cnt_r == 3'h0) begin
            hold_n_r <= 1'b0; // [R10]
          end else begin
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == HALF_LAST) begin
              sck_r <= 1'b1;
              cnt_r <= 3'h0;
              st_r <= HS_HIGH;
            end
          end
        end
        HS_HIGH: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == HALF_LAST) begin
            // Sampled late in the high half to cover both synchronisers
            rx_r <= {rx_r[4:0], miso_s_r};
            cnt_r <= 3'h0;
            if (n_r == FRAME_LAST) begin
              sck_r <= cpol_r;
              st_r <= HS_TAIL;
            end else begin
              sck_r <= 1'b0;
              si_r <= tx_r[14];
              tx_r <= {tx_r[14:0], 1'b0};
              n_r <= n_r + 4'h1;
              st_r <= HS_LOW;
            end
          end
        end
        HS_TAIL: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == HALF_LAST) begin
            cs_n_r <= 1'b1;
            rd_data_r <= rx_r;
            done_r <= 1'b1;
            st_r <= HS_IDLE;
          end
        end
        default: begin
          st_r <= HS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wp_n_r <= 1'b1;
    end else begin
      wp_n_r <= !protect;
    end
  end

  assign bus.cs_n = cs_n_r;
  assign bus.sck = sck_r;
  assign bus.si = si_r;
  assign bus.hold_n = hold_n_r;
  assign bus.wp_n = wp_n_r;
  assign req_ready = (st_r == HS_IDLE);
  assign rd_data = rd_data_r;
  assign done = done_r;

endmodule : qps_host
`default_nettype wire

// ---- qps_link_properties.sv ----
// Checker for the quad pot serial link between host and device ends.
// Sees the interface signals only; instanced beside the link.
`timescale 1ns/1ps
`default_nettype none
module qps_link_properties (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic so
);
  logic sck_q;
  logic [4:0] rise_cnt_r;

  always_ff @(posedge sys_clk) begin
    if (!resetn) sck_q <= 1'b0;
    else sck_q <= sck;
  end

  // Rises per frame; cleared while deselected
  always_ff @(posedge sys_clk) begin
    if (!resetn || cs_n) rise_cnt_r <= 5'h00;
    else if (sck && !sck_q) rise_cnt_r <= rise_cnt_r + 5'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_frame_bits: assert property (
    $rose(cs_n) |-> rise_cnt_r == 5'h10)
    else $error("frame did not carry 16 clock rises");
  chk_si_stable_high: assert property (
    rise_cnt_r inside {[5'h01:5'h0f]} && sck && $past(sck) |-> $stable(si))
    else $error("serial input moved while clock high");
  chk_so_stable_high: assert property (
    so_oe && sck && $past(sck) && $past(sck, 2) |-> $stable(so_o))
    else $error("serial output moved while clock high");
  chk_so_off_desel: assert property (
    cs_n [*5] |-> !so_oe)
    else $error("output driven while deselected");
  chk_so_off_pause: assert property (
    !hold_n [*5] |-> !so_oe)
    else $error("output driven while paused");
  chk_pause_sck_low: assert property (
    $changed(hold_n) |-> !sck)
    else $error("pause moved while clock high");
  chk_sck_frozen: assert property (
    !hold_n && !$past(hold_n) |-> $stable(sck))
    else $error("clock moved while paused");
  chk_so_late_on: assert property (
    $rose(so_oe) |-> !cs_n && hold_n && rise_cnt_r >= 5'h0a)
    else $error("output enabled outside data byte");
  chk_so_pulled_up: assert property (
    !so_oe |-> so)
    else $error("released serial output not read as high");

  cover property ($rose(so_oe));
  cover property ($fell(hold_n));
  cover property ($rose(cs_n) && sck);
  cover property (!cs_n && $fell(wp_n));
endmodule : qps_link_properties
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench: host end and device end joined by one link.
// Assumes the link interface and both ends compile before this file.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import qps_pkg::*;
  localparam logic [1:0] DEV_ADDR = 2'h1;
  logic sys_clk, resetn, mode_cpol, req_valid, req_ready, pause, protect;
  logic [7:0] req_instr, req_data;
  logic [5:0] rd_data;
  logic done, standby, nv_busy, busy_seen, busy_stby;
  logic [NPOT-1:0][WW-1:0] wsr;
  int errors, n_checks, cyc;

  qps_link_if link();
  qps_dev #(.NV_WRITE_CYC(4)) i_qps_dev (.sys_clk(sys_clk),
    .resetn(resetn), .bus(link), .strap_addr_lsb(DEV_ADDR[0]),
    .strap_addr_msb(DEV_ADDR[1]), .wiper_setting_reg(wsr),
    .standby(standby), .nv_busy(nv_busy));
  qps_host i_qps_host (.sys_clk(sys_clk), .resetn(resetn), .bus(link),
    .mode_cpol(mode_cpol), .req_valid(req_valid), .req_ready(req_ready),
    .req_instr(req_instr), .req_data(req_data), .pause(pause),
    .protect(protect), .rd_data(rd_data), .done(done));
  qps_link_properties i_qps_link_properties (.sys_clk(sys_clk),
    .resetn(resetn), .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
    .hold_n(link.hold_n), .wp_n(link.wp_n), .so_o(link.so_o),
    .so_oe(link.so_oe), .so(link.so));

  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // Whole run is about 4000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 12000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic cmp6(input logic [5:0] got, input logic [5:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp6

  task automatic cmp1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp1

  function automatic logic [7:0] cmd(input logic [3:0] op,
                                     input logic [1:0] pot);
    return {op, DEV_ADDR, pot};
  endfunction : cmd

  // One frame; optional pause window and protect fall, cycles after take.
  // Long idle tail so a slot write finishes before the next frame.
  task automatic frame(input logic [7:0] ins, input logic [7:0] dat,
                       input int p_at, input int w_at);
    int i;
    req_instr = ins;
    req_data = dat;
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    cmp1(req_ready, 1'b0);
    for (i = 0; i < 400 && done !== 1'b1; i++) begin
      pause = (i >= p_at && i < p_at + 30);
      if (i == w_at) protect = 1'b1;
      @(negedge sys_clk);
    end
    if (i == 400) begin
      errors++;
      wrap_up();
    end
    busy_seen = 1'b0;
    busy_stby = 1'b0;
    repeat (14) begin
      @(negedge sys_clk);
      i++;
      // Late protect fall lands while the slot write runs
      if (i == w_at) protect = 1'b1;
      busy_seen |= (nv_busy === 1'b1);
      busy_stby |= (nv_busy === 1'b1 && standby !== 1'b0);
    end
  endtask : frame

  ////////////////////////////////////////////////////////////////////////
  task automatic t_boot;
    for (int p = 0; p < NPOT; p++) cmp6(wsr[p], 6'h20);
    cmp1(standby, 1'b1);
  endtask : t_boot

  task automatic t_wiper;
    for (int m = 0; m < 2; m++) begin
      mode_cpol = m[0];
      repeat (4) @(negedge sys_clk);
      frame(cmd(OP_WR_WIPER, 2'h1), 8'h3f - 8'(m), 1000, 1000);
      cmp6(wsr[1], 6'h3f - 6'(m));
      cmp1(busy_seen, 1'b0);
      frame(cmd(OP_RD_WIPER, 2'h1), 8'h00, 1000, 1000);
      cmp6(rd_data, 6'h3f - 6'(m));
    end
    mode_cpol = 1'b0;
  endtask : t_wiper

  task automatic t_bad;
    frame({OP_WR_WIPER, 2'h2, 2'h1}, 8'h05, 1000, 1000);
    cmp6(wsr[1], 6'h3e);
    frame({OP_WR_WIPER, 2'h3, 2'h2}, 8'h05, 1000, 1000);
    cmp6(wsr[2], 6'h20);
    frame({4'h0, DEV_ADDR, 2'h1}, 8'h05, 1000, 1000);
    cmp6(wsr[1], 6'h3e);
    frame({OP_RD_WIPER, 2'h2, 2'h1}, 8'h00, 1000, 1000);
    cmp6(rd_data, 6'h3f);
  endtask : t_bad

  task automatic t_slot;
    frame(cmd(OP_WR_SLOT, 2'h2), {2'h3, 6'h15}, 1000, 1000);
    cmp1(busy_seen, 1'b1);
    cmp1(busy_stby, 1'b0);
    frame(cmd(OP_RD_SLOT, 2'h2), {2'h3, 6'h00}, 1000, 1000);
    cmp6(rd_data, 6'h15);
    protect = 1'b1;
    frame(cmd(OP_WR_SLOT, 2'h2), {2'h3, 6'h2a}, 1000, 1000);
    cmp1(busy_seen, 1'b0);
    frame(cmd(OP_WR_WIPER, 2'h2), 8'h11, 1000, 1000);
    cmp6(wsr[2], 6'h11);
    protect = 1'b0;
    // Protect falls after the last bit, before chip select rises
    frame(cmd(OP_WR_SLOT, 2'h2), {2'h3, 6'h2a}, 1000, 130);
    cmp1(busy_seen, 1'b0);
    protect = 1'b0;
    frame(cmd(OP_RD_SLOT, 2'h2), {2'h3, 6'h00}, 1000, 1000);
    cmp6(rd_data, 6'h15);
    frame(cmd(OP_WR_SLOT, 2'h2), {2'h2, 6'h2a}, 1000, 137);
    cmp1(busy_seen, 1'b1);
    protect = 1'b0;
    frame(cmd(OP_RD_SLOT, 2'h2), {2'h2, 6'h00}, 1000, 1000);
    cmp6(rd_data, 6'h2a);
  endtask : t_slot

  task automatic t_copy;
    frame(cmd(OP_COPY, 2'h2), {2'h1, 6'h20}, 1000, 1000);
    cmp1(busy_seen, 1'b1);
    frame(cmd(OP_RD_SLOT, 2'h2), {2'h1, 6'h00}, 1000, 1000);
    cmp6(rd_data, 6'h11);
    frame(cmd(OP_COPY, 2'h2), {2'h3, 6'h00}, 1000, 1000);
    cmp6(wsr[2], 6'h15);
  endtask : t_copy

  task automatic t_step;
    frame(cmd(OP_WR_WIPER, 2'h0), 8'h3d, 1000, 1000);
    frame(cmd(OP_STEP, 2'h0), 8'hff, 1000, 1000);
    cmp6(wsr[0], 6'h3f);
    frame(cmd(OP_WR_WIPER, 2'h0), 8'h02, 1000, 1000);
    frame(cmd(OP_STEP, 2'h0), 8'h0f, 1000, 1000);
    cmp6(wsr[0], 6'h04);
  endtask : t_step

  task automatic t_pause;
    frame(cmd(OP_WR_WIPER, 2'h3), 8'h2b, 50, 1000);
    cmp6(wsr[3], 6'h2b);
    frame(cmd(OP_RD_WIPER, 2'h3), 8'h00, 95, 1000);
    cmp6(rd_data, 6'h2b);
    cmp6(wsr[1], 6'h3e);
  endtask : t_pause

  ////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    mode_cpol = 1'b0;
    req_valid = 1'b0;
    req_instr = 8'h00;
    req_data = 8'h00;
    pause = 1'b0;
    protect = 1'b0;
    busy_seen = 1'b0;
    busy_stby = 1'b0;
    repeat (6) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (8) @(negedge sys_clk);
    t_boot();
    t_wiper();
    t_bad();
    t_slot();
    t_copy();
    t_step();
    t_pause();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
